/* shared/bds_pkg.sv */
package bds_pkg;

  localparam int CLK_MHZ = 40;
  // Filter and reset times in nanoseconds; values are plain defaults.
  localparam int T_OVT_NS     = 1000;
  localparam int T_OVP_NS     = 2000;
  localparam int T_OVP_RST_NS = 2000;
  localparam int T_OVT_CYC     = (T_OVT_NS * CLK_MHZ + 999) / 1000;
  localparam int T_OVP_CYC     = (T_OVP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_OVP_RST_CYC = (T_OVP_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W        = 8;

  localparam logic [5:0] STATUS_ONE_ADDR = 6'h06;

  localparam int POS_OVT      = 20;
  localparam int POS_TW2      = 19;
  localparam int POS_TW1      = 18;
  localparam int POS_LOGIC_UV = 17;
  localparam int POS_WD_PROG  = 15;
  localparam int POS_WATCHDOG_FAILURE  = 14;
  localparam int POS_MAIN_UV  = 13;
  localparam int POS_REG_FED  = 11;
  localparam int POS_NOT_GOOD = 8;
  localparam int POS_OVP      = 7;
  localparam int POS_PARITY   = 0;

  localparam logic [23:0] STATUS_RESET = 24'h000000;

  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic       read_clear;
    logic       parity;
  } bds_req_t;

  typedef struct packed {
    logic tj_tsd;
    logic tj_ge_tw2;
    logic tj_ge_tw1;
    logic tj_lt_tw1;
    logic tj_lt_tw1_hys;
  } bds_therm_t;

  typedef struct packed {
    logic vdd_uv;
    logic vs_le_uv;
    logic vs_gt_uv_hys;
    logic vs_le_lv;
    logic vs_gt_lv_hys;
    logic out_ge_15v;
    logic out_below_pg;
    logic fb_ov_on;
    logic fb_below_ov_off;
  } bds_supply_t;

  function automatic logic odd_parity(input logic [23:1] data);
    return ~(^data);
  endfunction : odd_parity

endpackage : bds_pkg

/* verilog/bds_status_one.sv */
`timescale 1ns/1ps

// Functional notes
// [R1] Overtemp in normal mode latches both phases off.
// [R2] Host clear works only below second warning.
// [R3] Fallback auto-restart clears, then resets if hot.
// [R4] High warning tracks, clears below first threshold.
// [R5] Low warning tracks with hysteresis, read only.
// [R6] Logic supply loss flags and enters fallback.
// [R7] Watchdog progress field reports elapsed quarter.
// [R8] Watchdog failure latches flag, enters fallback.
// [R9] Main undervolt flag with hysteresis and changeover.
// [R10] Changeover flag: main low and output >=15V.
// [R11] Not-good flag set below 92.5% target.
// [R12] Not-good held clear while phases disabled.
// [R13] Overvoltage flag set/reset after filter times.
// [R14] Overvoltage never set when disabled or pin fails.
// [R15] Every frame carries odd parity in bit zero.
// [R16] Read-clear flags stay set while cause persists; watchdog expiry is ignored in fallback, so its flag can still clear.
module bds_status_one #(
  parameter int AUTORESTART_CYC = 40000
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire bds_pkg::bds_req_t     req_in,
  input  wire bds_pkg::bds_therm_t   therm_in,
  input  wire bds_pkg::bds_supply_t  supply_in,
  input  wire logic [1:0]            watchdog_progress_in,
  input  wire logic                  watchdog_expire_in,
  input  wire logic [1:0]            phase_disable_in,
  input  wire logic                  output_pin_failure_in,
  output logic [23:0]                rdata_out,
  output logic                       rvalid_out,
  output logic                       phases_off_out,
  output logic                       fallback_mode_out
);

  localparam int FILT_W_L = bds_pkg::FILT_W;
  localparam logic [FILT_W_L-1:0] OVT_CYC     = FILT_W_L'(bds_pkg::T_OVT_CYC);
  localparam logic [FILT_W_L-1:0] OVP_CYC     = FILT_W_L'(bds_pkg::T_OVP_CYC);
  localparam logic [FILT_W_L-1:0] OVP_RST_CYC = FILT_W_L'(bds_pkg::T_OVP_RST_CYC);

  logic        overtemp_shutdown_flag_r, overtemp_shutdown_flag_nxt;
  logic        thermal_warn_high_r, thermal_warn_high_nxt;
  logic        thermal_warn_low_r, thermal_warn_low_nxt;
  logic        logic_supply_missing_r, logic_supply_missing_nxt;
  logic [1:0]  watchdog_progress_r, watchdog_progress_nxt;
  logic        watchdog_failure_r, watchdog_failure_nxt;
  logic        main_supply_undervolt_r, main_supply_undervolt_nxt;
  logic        regulator_fed_from_output_r, regulator_fed_from_output_nxt;
  logic        output_not_good_r, output_not_good_nxt;
  logic        output_overvolt_flag_r, output_overvolt_flag_nxt;
  logic        fallback_r, fallback_nxt;
  logic [FILT_W_L-1:0] ovt_cnt_r, ovt_cnt_nxt;
  logic [FILT_W_L-1:0] ovp_cnt_r, ovp_cnt_nxt;
  logic [31:0] restart_cnt_r, restart_cnt_nxt;
  logic [23:0] rdata_nxt;
  logic        rvalid_nxt;
  logic [23:0] status_w;
  logic        frame_ok_w, hit_w, clear_w, restart_tick_w, ovt_set_w, ovp_block_w;

  always_comb begin
    status_w = bds_pkg::STATUS_RESET;
    status_w[bds_pkg::POS_OVT]      = overtemp_shutdown_flag_r;
    status_w[bds_pkg::POS_TW2]      = thermal_warn_high_r;
    status_w[bds_pkg::POS_TW1]      = thermal_warn_low_r;
    status_w[bds_pkg::POS_LOGIC_UV] = logic_supply_missing_r;
    status_w[bds_pkg::POS_WD_PROG +: 2] = watchdog_progress_r; // [R7]
    status_w[bds_pkg::POS_WATCHDOG_FAILURE]  = watchdog_failure_r;
    status_w[bds_pkg::POS_MAIN_UV]  = main_supply_undervolt_r;
    status_w[bds_pkg::POS_REG_FED]  = regulator_fed_from_output_r;
    status_w[bds_pkg::POS_NOT_GOOD] = output_not_good_r;
    status_w[bds_pkg::POS_OVP]      = output_overvolt_flag_r;
    status_w[bds_pkg::POS_PARITY]   = bds_pkg::odd_parity(status_w[23:1]); // [R15]
  end

  // A request frame with even parity is dropped entirely.
  assign frame_ok_w = req_in.valid && (^{req_in.addr, req_in.read_clear, req_in.parity}); // [R15]
  assign hit_w      = frame_ok_w && (req_in.addr == bds_pkg::STATUS_ONE_ADDR);
  assign clear_w    = hit_w && req_in.read_clear;
  assign restart_tick_w = fallback_r && (restart_cnt_r == 32'(AUTORESTART_CYC - 1));
  assign ovt_set_w  = therm_in.tj_tsd && (ovt_cnt_r == OVT_CYC);
  assign ovp_block_w = (phase_disable_in != 2'h0) || output_pin_failure_in;

  always_comb begin
    rvalid_nxt = frame_ok_w;
    rdata_nxt  = hit_w ? status_w : {23'h000000, bds_pkg::odd_parity(23'h000000)}; // [R15]
    ovt_cnt_nxt = therm_in.tj_tsd ? ((ovt_cnt_r == OVT_CYC) ? ovt_cnt_r
                                                           : ovt_cnt_r + 1'b1)
                                  : '0;
    restart_cnt_nxt = (fallback_r && !restart_tick_w) ? restart_cnt_r + 32'h1 : 32'h0;
    overtemp_shutdown_flag_nxt = overtemp_shutdown_flag_r;
    if (clear_w && !therm_in.tj_ge_tw2) begin
      overtemp_shutdown_flag_nxt = 1'b0; // [R2]
    end
    if (restart_tick_w) begin
      // Only a flag that was already set may be re-armed by the restart.
      overtemp_shutdown_flag_nxt = overtemp_shutdown_flag_r && therm_in.tj_ge_tw2; // [R3]
    end
    if (ovt_set_w) begin
      overtemp_shutdown_flag_nxt = 1'b1; // [R16]
    end
    if (therm_in.tj_ge_tw2) begin
      thermal_warn_high_nxt = 1'b1; // [R4]
    end else if (therm_in.tj_lt_tw1) begin
      thermal_warn_high_nxt = 1'b0; // [R4]
    end else begin
      thermal_warn_high_nxt = thermal_warn_high_r;
    end
    if (therm_in.tj_ge_tw1) begin
      thermal_warn_low_nxt = 1'b1; // [R5]
    end else if (therm_in.tj_lt_tw1_hys) begin
      thermal_warn_low_nxt = 1'b0; // [R5]
    end else begin
      thermal_warn_low_nxt = thermal_warn_low_r;
    end
    logic_supply_missing_nxt = supply_in.vdd_uv; // [R6]
    watchdog_progress_nxt    = watchdog_progress_in; // [R7]
    watchdog_failure_nxt = watchdog_failure_r && !clear_w;
    if (watchdog_expire_in && !fallback_r) begin
      watchdog_failure_nxt = 1'b1; // [R8] [R16]
    end
    // Fallback is left only when the supply is back and no failure is latched.
    fallback_nxt = fallback_r;
    if (supply_in.vdd_uv || (watchdog_expire_in && !fallback_r)) begin
      fallback_nxt = 1'b1; // [R6] [R8]
    end else if (!watchdog_failure_r) begin
      fallback_nxt = 1'b0;
    end
    if (supply_in.vs_le_lv && supply_in.out_ge_15v) begin
      regulator_fed_from_output_nxt = 1'b1; // [R10]
    end else if (supply_in.vs_gt_lv_hys || !supply_in.out_ge_15v) begin
      regulator_fed_from_output_nxt = 1'b0; // [R10]
    end else begin
      regulator_fed_from_output_nxt = regulator_fed_from_output_r;
    end
    if (supply_in.vs_gt_uv_hys || regulator_fed_from_output_r) begin
      main_supply_undervolt_nxt = 1'b0; // [R9]
    end else if (supply_in.vs_le_uv) begin
      main_supply_undervolt_nxt = 1'b1; // [R9]
    end else begin
      main_supply_undervolt_nxt = main_supply_undervolt_r;
    end
    output_not_good_nxt = supply_in.out_below_pg && (phase_disable_in == 2'h0); // [R11] [R12]
    output_overvolt_flag_nxt = output_overvolt_flag_r;
    ovp_cnt_nxt = '0;
    if (ovp_block_w) begin
      output_overvolt_flag_nxt = 1'b0; // [R14]
    end else if (!output_overvolt_flag_r && supply_in.fb_ov_on) begin
      ovp_cnt_nxt = ovp_cnt_r + 1'b1;
      if (ovp_cnt_r == OVP_CYC - 1'b1) begin
        output_overvolt_flag_nxt = 1'b1; // [R13]
        ovp_cnt_nxt = '0;
      end
    end else if (output_overvolt_flag_r && supply_in.fb_below_ov_off) begin
      ovp_cnt_nxt = ovp_cnt_r + 1'b1;
      if (ovp_cnt_r == OVP_RST_CYC - 1'b1) begin
        output_overvolt_flag_nxt = 1'b0; // [R13]
        ovp_cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_shutdown_flag_r    <= 1'b0;
      thermal_warn_high_r         <= 1'b0;
      thermal_warn_low_r          <= 1'b0;
      logic_supply_missing_r      <= 1'b0;
      watchdog_progress_r         <= 2'h0;
      watchdog_failure_r          <= 1'b0;
      main_supply_undervolt_r     <= 1'b0;
      regulator_fed_from_output_r <= 1'b0;
      output_not_good_r           <= 1'b0;
      output_overvolt_flag_r      <= 1'b0;
      fallback_r                  <= 1'b0;
      ovt_cnt_r                   <= '0;
      ovp_cnt_r                   <= '0;
      restart_cnt_r               <= 32'h0;
      rdata_out                   <= 24'h000000;
      rvalid_out                  <= 1'b0;
    end else begin
      overtemp_shutdown_flag_r    <= overtemp_shutdown_flag_nxt;
      thermal_warn_high_r         <= thermal_warn_high_nxt;
      thermal_warn_low_r          <= thermal_warn_low_nxt;
      logic_supply_missing_r      <= logic_supply_missing_nxt;
      watchdog_progress_r         <= watchdog_progress_nxt;
      watchdog_failure_r          <= watchdog_failure_nxt;
      main_supply_undervolt_r     <= main_supply_undervolt_nxt;
      regulator_fed_from_output_r <= regulator_fed_from_output_nxt;
      output_not_good_r           <= output_not_good_nxt;
      output_overvolt_flag_r      <= output_overvolt_flag_nxt;
      fallback_r                  <= fallback_nxt;
      ovt_cnt_r                   <= ovt_cnt_nxt;
      ovp_cnt_r                   <= ovp_cnt_nxt;
      restart_cnt_r               <= restart_cnt_nxt;
      rdata_out                   <= rdata_nxt;
      rvalid_out                  <= rvalid_nxt;
    end
  end

  assign phases_off_out    = overtemp_shutdown_flag_r; // [R1]
  assign fallback_mode_out = fallback_r;

  chk_ovt_phases_off: assert property (@(posedge clk_in) disable iff (reset_in) // [R1]
    (overtemp_shutdown_flag_r && !clear_w && !restart_tick_w) |=> phases_off_out)
    else $error("Phases not off while overtemp flag set.");

  chk_ovt_hot_clear: assert property (@(posedge clk_in) disable iff (reset_in) // [R2]
    (overtemp_shutdown_flag_r && clear_w && therm_in.tj_ge_tw2) |=> overtemp_shutdown_flag_r)
    else $error("Overtemp cleared while still above second warning.");

  chk_ovt_restart: assert property (@(posedge clk_in) disable iff (reset_in) // [R3]
    (restart_tick_w && !therm_in.tj_ge_tw2 && !ovt_set_w) |=> !overtemp_shutdown_flag_r)
    else $error("Auto restart did not clear overtemp flag.");

  chk_tw2_track: assert property (@(posedge clk_in) disable iff (reset_in) // [R4]
    therm_in.tj_ge_tw2 |=> thermal_warn_high_r)
    else $error("High warning not set at threshold.");

  chk_tw1_release: assert property (@(posedge clk_in) disable iff (reset_in) // [R5]
    (therm_in.tj_lt_tw1_hys && !therm_in.tj_ge_tw1) |=> !thermal_warn_low_r)
    else $error("Low warning not cleared below hysteresis.");

  chk_supply_fallback: assert property (@(posedge clk_in) disable iff (reset_in) // [R6]
    supply_in.vdd_uv |=> (logic_supply_missing_r && fallback_r))
    else $error("Logic supply loss did not enter fallback.");

  chk_watchdog_failure_mode: assert property (@(posedge clk_in) disable iff (reset_in) // [R8]
    (watchdog_expire_in && !fallback_r) |=> (watchdog_failure_r && fallback_r))
    else $error("Watchdog failure not latched with fallback.");

  chk_pg_disabled: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    (phase_disable_in != 2'h0) |=> !output_not_good_r)
    else $error("Not-good flag set while phases disabled.");

  chk_ovp_blocked: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    ovp_block_w |=> !output_overvolt_flag_r)
    else $error("Overvoltage flag set while blocked.");

  chk_frame_parity: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    rvalid_out |-> (^rdata_out))
    else $error("Answer frame parity is not odd.");

  chk_ovp_filter: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
    $rose(output_overvolt_flag_r) |-> $past(supply_in.fb_ov_on))
    else $error("Overvoltage flag rose without feedback above on level.");

endmodule : bds_status_one

/* test/bds_host_model.sv */
`timescale 1ns/1ps

module bds_host_model (
  input  wire logic        clk_in,
  input  wire logic [23:0] rdata_in,
  input  wire logic        rvalid_in,
  output bds_pkg::bds_req_t req_out
);
  initial req_out = '0;

  // Sends one request and returns what comes back one cycle later.
  task automatic send(input logic [5:0] a, input logic rc, input logic bad,
                      output logic v, output logic [23:0] d);
    @(negedge clk_in);
    req_out.valid      = 1'b1;
    req_out.addr       = a;
    req_out.read_clear = rc;
    req_out.parity     = ~(^{a, rc}) ^ bad;
    @(negedge clk_in);
    v       = rvalid_in;
    d       = rdata_in;
    req_out = {1'b0, ~req_out.addr, ~req_out.read_clear, ~req_out.parity};
  endtask : send
endmodule : bds_host_model

/* test/tb.sv */
`timescale 1ns/1ps

module tb;
  localparam int AR = 20;
  localparam logic [8:0] SOK = 9'h051;
  logic clk_in, reset_in, wde, pinf, rv, poff, fb;
  logic [1:0] wdp, dis;
  logic [23:0] rd;
  bds_pkg::bds_req_t    req;
  bds_pkg::bds_therm_t  th;
  bds_pkg::bds_supply_t su;
  int num_errors, compares, cyc;

  bds_status_one #(.AUTORESTART_CYC(AR)) bds_status_one_inst (
    .clk_in(clk_in), .reset_in(reset_in), .req_in(req), .therm_in(th),
    .supply_in(su), .watchdog_progress_in(wdp), .watchdog_expire_in(wde),
    .phase_disable_in(dis), .output_pin_failure_in(pinf), .rdata_out(rd),
    .rvalid_out(rv), .phases_off_out(poff), .fallback_mode_out(fb));

  bds_host_model bds_host_model_inst (
    .clk_in(clk_in), .rdata_in(rd), .rvalid_in(rv), .req_out(req));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic go(input int n);
    repeat (n) @(negedge clk_in);
  endtask : go

  task automatic rdc(input logic rc, input logic [23:0] e);
    logic v;
    logic [23:0] d;
    bds_host_model_inst.send(6'h06, rc, 1'h0, v, d);
    cmp({23'h0, v}, 24'h1);
    cmp(d, {e[23:1], ~(^e[23:1])});
  endtask : rdc

  task automatic t_live();
    for (int q = 0; q < 4; q++) begin
      wdp = q[1:0];
      go(2);
      rdc(1'h0, {7'h0, q[1:0], 15'h0});
    end
    wdp = 2'h0;
    th = 5'h0c;
    go(2);
    rdc(1'h0, 24'h0c0000);
    th = 5'h04;
    go(2);
    rdc(1'h0, 24'h0c0000);
    th = 5'h02;
    go(2);
    rdc(1'h0, 24'h040000);
    th = 5'h03;
    go(2);
    rdc(1'h0, 24'h000000);
    su = 9'h081;
    go(2);
    rdc(1'h0, 24'h002000);
    su = 9'h0a9;
    go(2);
    rdc(1'h0, 24'h000800);
    su = SOK | 9'h004;
    go(2);
    rdc(1'h0, 24'h000100);
    dis = 2'h1;
    go(2);
    rdc(1'h0, 24'h000000);
    dis = 2'h0;
    su = SOK;
  endtask : t_live

  task automatic t_ovt();
    th = 5'h1c;
    go(bds_pkg::T_OVT_CYC + 4);
    cmp({23'h0, poff}, 24'h1);
    th = 5'h0c;
    go(2);
    rdc(1'h1, 24'h1c0000);
    cmp({23'h0, poff}, 24'h1);
    rdc(1'h0, 24'h1c0000);
    th = 5'h03;
    go(2);
    rdc(1'h1, 24'h100000);
    rdc(1'h0, 24'h000000);
    cmp({23'h0, poff}, 24'h0);
  endtask : t_ovt

  task automatic t_wd();
    wde = 1'h1;
    go(1);
    wde = 1'h0;
    go(2);
    cmp({23'h0, fb}, 24'h1);
    rdc(1'h1, 24'h004000);
    rdc(1'h0, 24'h000000);
  endtask : t_wd

  task automatic t_auto();
    su = SOK | 9'h100;
    go(2);
    rdc(1'h0, 24'h020000);
    cmp({23'h0, fb}, 24'h1);
    th = 5'h0c;
    go(AR + 4);
    cmp({23'h0, poff}, 24'h0);
    th = 5'h1c;
    go(bds_pkg::T_OVT_CYC + 4 + 3 * AR);
    cmp({23'h0, poff}, 24'h1);
    th = 5'h03;
    go(AR + 6);
    cmp({23'h0, poff}, 24'h0);
    su = SOK;
    go(2);
  endtask : t_auto

  task automatic t_ovp();
    su = SOK ^ 9'h003;
    go(bds_pkg::T_OVP_CYC - 6);
    rdc(1'h0, 24'h0);
    go(10);
    rdc(1'h0, 24'h000080);
    su = SOK;
    go(bds_pkg::T_OVP_RST_CYC + 4);
    rdc(1'h0, 24'h0);
    dis = 2'h2;
    su = SOK ^ 9'h003;
    go(bds_pkg::T_OVP_CYC + 8);
    rdc(1'h0, 24'h0);
    pinf = 1'h1;
    dis = 2'h0;
    go(bds_pkg::T_OVP_CYC + 8);
    rdc(1'h0, 24'h0);
    pinf = 1'h0;
    su = SOK;
    go(bds_pkg::T_OVP_RST_CYC + 4);
  endtask : t_ovp

  task automatic t_refuse();
    logic v;
    logic [23:0] d;
    bds_host_model_inst.send(6'h06, 1'h0, 1'h1, v, d);
    cmp({23'h0, v}, 24'h0);
    bds_host_model_inst.send(6'h07, 1'h1, 1'h0, v, d);
    cmp(d, 24'h000001);
  endtask : t_refuse

  initial begin
    reset_in = 1'h1;
    th = 5'h03;
    su = SOK;
    wdp = 2'h0;
    wde = 1'h0;
    dis = 2'h0;
    pinf = 1'h0;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    go(20);
    reset_in = 1'h0;
    rdc(1'h0, 24'h000000);
    cmp({22'h0, poff, fb}, 24'h0);
    t_live();
    t_ovt();
    t_wd();
    t_auto();
    t_ovp();
    t_refuse();
    test_done();
  end
endmodule : tb
